/* File: logic/lsa_light_sensor.sv */
// Purpose: Control, integration timing and readout of a light sensor converter
// Assumes: Diode inputs are modulator pulse streams, one pulse per charge packet
// Notes:   Converter oscillator is a tick divided from clk
`timescale 1ns/1ps
module lsa_light_sensor import lsa_pkg::*; (
	input  wire logic        clk,          // System clock, 10 MHz
	input  wire logic        rst,          // Synchronous reset, active high
	input  wire logic        sclIn,        // Serial clock pin
	input  wire logic        sdaIn,        // Serial data pin level
	output logic             sdaOut,       // Serial data drive value
	output logic             sdaOe,        // Serial data pull-low enable
	input  wire logic        diode1Pulse,  // Diode one modulator pulses
	input  wire logic        diode2Pulse,  // Diode two modulator pulses
	output logic             intN,         // Interrupt, active low
	output logic             powerDown,    // Analog power-down request
	output logic [1:0]       diodeSel,     // Photodiode mux setting
	output logic [16:0]      fullScaleSpan // Selected range constant
);
	function automatic logic [16:0] widthCycles(input logic [1:0] w);
		unique case (w)
			2'h0: widthCycles = 17'h10000;
			2'h1: widthCycles = 17'h01000;
			2'h2: widthCycles = 17'h00100;
			default: widthCycles = 17'h00010;
		endcase
	endfunction

	function automatic logic [4:0] persistCycles(input logic [1:0] p);
		unique case (p)
			2'h0: persistCycles = 5'h01;
			2'h1: persistCycles = 5'h04;
			2'h2: persistCycles = 5'h08;
			default: persistCycles = 5'h10;
		endcase
	endfunction

	function automatic logic [16:0] spanOf(input logic [1:0] g);
		unique case (g)
			2'h0: spanOf = 17'd973;
			2'h1: spanOf = 17'd3892;
			2'h2: spanOf = 17'd15568;
			default: spanOf = 17'd62272;
		endcase
	endfunction

	logic [3:0]  pins;
	logic        d1D_q;
	logic        d2D_q;
	lsa_hostwr_t hostWr;
	logic [2:0]  rdAddr;
	logic [7:0]  rdData_q;

	logic [7:0]  cmd_q;
	logic [7:0]  ctl_q;
	logic [7:0]  hiThr_q;
	logic [7:0]  loThr_q;
	logic        intFlag_q;
	logic [4:0]  divCnt_q;
	logic [16:0] oscCnt_q;
	logic [15:0] timer_q;
	logic [15:0] tmrCap_q;
	logic [15:0] pulseCnt_q;
	logic [15:0] firstCnt_q;
	logic        phase_q;
	logic [15:0] result_q;
	logic        evalNow_q;
	logic [4:0]  persist_q;

	lsa_sync2 #(.W(4)) u_sync (
		.clk  (clk),
		.rst  (rst),
		.din  ({sclIn, sdaIn, diode1Pulse, diode2Pulse}),
		.idle (4'hC),
		.dout (pins)
	);

	lsa_twowire_slave u_slave (
		.clk    (clk),
		.rst    (rst),
		.scl    (pins[3]),
		.sda    (pins[2]),
		.sdaOe  (sdaOe),
		.hostWr (hostWr),
		.rdAddr (rdAddr),
		.rdData (rdData_q)
	);

	wire       coreRun  = cmd_q[CMD_EN] & ~cmd_q[CMD_PD];
	wire       extMode  = cmd_q[CMD_TIM];
	wire [1:0] muxMode  = cmd_q[MUX_LO +: 2];
	wire [1:0] gain     = ctl_q[GAIN_LO +: 2];
	wire [16:0] target  = widthCycles(cmd_q[WID_LO +: 2]);
	wire [4:0] divLimit = gain[1] ? DIV_FAST - 5'h1 : DIV_SLOW - 5'h1;
	wire       oscTick  = coreRun && divCnt_q >= divLimit;
	wire       d1Edge   = pins[1] & ~d1D_q;
	wire       d2Edge   = pins[0] & ~d2D_q;
	wire       clearCmd = hostWr.clearCmd;

	// Internal timing ends on the cycle count, external on the host sync strobe
	wire endInteg = coreRun && muxMode != MUX_NOP &&
		(extMode ? hostWr.syncCmd : (oscTick && oscCnt_q >= target - 17'h1));

	wire [15:0] satMax = extMode ? 16'hFFFF : 16'(target - 17'h1);
	wire useD2 = muxMode == MUX_D2 || (muxMode == MUX_DIFF && phase_q);
	wire diodeHit = useD2 ? d2Edge : d1Edge;
	wire [16:0] diffWide = {1'b0, firstCnt_q} - {1'b0, pulseCnt_q};

	wire [15:0] hiFull = {hiThr_q, 8'h00};
	wire [15:0] loFull = {loThr_q, 8'h00};
	wire outside = result_q > hiFull || result_q < loFull;
	wire [4:0] persistM = persistCycles(ctl_q[PER_LO +: 2]);
	wire setFlag = evalNow_q && outside && persist_q >= persistM - 5'h1;

	always_ff @(posedge clk) begin
		if (rst) begin
			d1D_q <= 1'b0;
			d2D_q <= 1'b0;
		end else begin
			d1D_q <= pins[1];
			d2D_q <= pins[0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_q   <= CMD_RESET;
			ctl_q   <= CTL_RESET;
			hiThr_q <= HI_RESET;
			loThr_q <= LO_RESET;
		end else if (hostWr.wrEn) begin
			unique case (hostWr.addr)
				REG_CMD: cmd_q   <= hostWr.data;
				REG_CTL: ctl_q   <= hostWr.data;
				REG_HI:  hiThr_q <= hostWr.data;
				REG_LO:  loThr_q <= hostWr.data;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdData_q <= 8'h00;
		end else begin
			unique case (rdAddr)
				REG_CMD:  rdData_q <= cmd_q;
				REG_CTL:  rdData_q <= {ctl_q[7:6], intFlag_q, ctl_q[4:0]};
				REG_HI:   rdData_q <= hiThr_q;
				REG_LO:   rdData_q <= loThr_q;
				REG_RESL: rdData_q <= result_q[7:0];
				REG_RESH: rdData_q <= result_q[15:8];
				REG_TMRL: rdData_q <= tmrCap_q[7:0];
				default:  rdData_q <= tmrCap_q[15:8];
			endcase
		end
	end

	// Divider restarts when the core is held, so ticks never leak out of reset
	always_ff @(posedge clk) begin
		if (rst || !coreRun) begin
			divCnt_q <= 5'h00;
		end else if (divCnt_q >= divLimit) begin
			divCnt_q <= 5'h00;
		end else begin
			divCnt_q <= divCnt_q + 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !coreRun || endInteg) begin
			oscCnt_q <= 17'h00000;
			timer_q  <= 16'h0000;
		end else if (oscTick) begin
			if (oscCnt_q != 17'h1FFFF) begin
				oscCnt_q <= oscCnt_q + 17'h00001;
			end
			if (timer_q != 16'hFFFF) begin
				timer_q <= timer_q + 16'h0001;
			end
		end
	end

	// In internal timing the capture only mirrors the cycle count, of no use to software
	always_ff @(posedge clk) begin
		if (rst) begin
			tmrCap_q <= 16'h0000;
		end else if (endInteg) begin
			tmrCap_q <= timer_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !coreRun || endInteg) begin
			pulseCnt_q <= 16'h0000;
		end else if (muxMode != MUX_NOP && diodeHit && pulseCnt_q < satMax) begin
			pulseCnt_q <= pulseCnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			phase_q    <= 1'b0;
			firstCnt_q <= 16'h0000;
			result_q   <= 16'h0000;
			evalNow_q  <= 1'b0;
		end else begin
			evalNow_q <= 1'b0;
			if (!coreRun) begin
				phase_q <= 1'b0;
			end else if (endInteg) begin
				if (muxMode == MUX_DIFF && !phase_q) begin
					firstCnt_q <= pulseCnt_q;
					phase_q    <= 1'b1;
				end else begin
					// Halving keeps the signed difference within n-1 magnitude bits
					result_q  <= muxMode == MUX_DIFF ? diffWide[16:1] : pulseCnt_q;
					phase_q   <= 1'b0;
					evalNow_q <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !coreRun) begin
			persist_q <= 5'h00;
		end else if (evalNow_q) begin
			if (!outside) begin
				persist_q <= 5'h00;
			end else if (persist_q != 5'h1F) begin
				persist_q <= persist_q + 5'h01;
			end
		end
	end

	// A trigger in the same cycle as a clear wins, so no event is lost
	always_ff @(posedge clk) begin
		if (rst) begin
			intFlag_q <= 1'b0;
			intN      <= 1'b1;
		end else begin
			intFlag_q <= setFlag | (intFlag_q & ~clearCmd);
			intN      <= ~(setFlag | (intFlag_q & ~clearCmd));
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sdaOut        <= 1'b0;
			powerDown     <= 1'b0;
			diodeSel      <= 2'h0;
			fullScaleSpan <= 17'd973;
		end else begin
			powerDown     <= cmd_q[CMD_PD];
			diodeSel      <= useD2 ? MUX_D2 : MUX_D1;
			fullScaleSpan <= spanOf(gain);
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence clearStrobe;
		clearCmd && !setFlag;
	endsequence
	sequence flagLow;
		!intFlag_q ##0 intN;
	endsequence

	chk_core_held: assert property (!coreRun |=> oscCnt_q == 17'h0 && pulseCnt_q == 16'h0)
		else $error("core counters run while held");
	chk_pd_tick: assert property (cmd_q[CMD_PD] |-> !oscTick)
		else $error("oscillator ticks in power-down");
	chk_int_end: assert property (coreRun && !extMode && muxMode != MUX_NOP && oscTick
		&& oscCnt_q == target - 17'h1 |-> endInteg)
		else $error("internal integration did not end");
	chk_ext_end: assert property (coreRun && extMode && muxMode != MUX_NOP && hostWr.syncCmd |-> endInteg)
		else $error("sync command did not end integration");
	chk_half_speed: assert property (oscTick && !gain[1] |-> divCnt_q == DIV_SLOW - 5'h1)
		else $error("low range tick at wrong rate");
	chk_flag_clear: assert property (clearStrobe |=> flagLow)
		else $error("clear did not drop flag");
	chk_flag_sticky: assert property (intFlag_q && !clearCmd |=> intFlag_q && !intN)
		else $error("flag dropped without clear");
	chk_flag_cause: assert property ($rose(intFlag_q) |-> $past(evalNow_q) && $past(outside))
		else $error("flag set without out-of-window reading");
	chk_pin_flag: assert property (intN == !intFlag_q)
		else $error("pin and flag disagree");
	chk_timer_cap: assert property (endInteg |=> tmrCap_q == $past(timer_q))
		else $error("timer not captured");
	chk_result_upd: assert property (endInteg && muxMode == MUX_D1 |=> result_q == $past(pulseCnt_q))
		else $error("result not refreshed");
	chk_thr_reset: assert property ($fell(rst) |-> hiThr_q == HI_RESET && loThr_q == LO_RESET)
		else $error("threshold reset values wrong");
endmodule

/* File: logic/lsa_pkg.sv */
// Purpose: Shared constants and carriers of the light sensor block
// Assumes: 10 MHz system clock
// Notes:   Register offsets are the serial bus register indices
package lsa_pkg;
	localparam int unsigned CLK_HZ      = 10_000_000;
	localparam int unsigned OSC_FAST_HZ = 655_000;
	localparam int unsigned OSC_SLOW_HZ = OSC_FAST_HZ / 2;
	localparam logic [4:0]  DIV_FAST    = 5'(CLK_HZ / OSC_FAST_HZ);
	localparam logic [4:0]  DIV_SLOW    = 5'(CLK_HZ / OSC_SLOW_HZ);
	localparam logic [6:0]  DEV_ADDR    = 7'h44;

	localparam logic [2:0] REG_CMD  = 3'h0;
	localparam logic [2:0] REG_CTL  = 3'h1;
	localparam logic [2:0] REG_HI   = 3'h2;
	localparam logic [2:0] REG_LO   = 3'h3;
	localparam logic [2:0] REG_RESL = 3'h4;
	localparam logic [2:0] REG_RESH = 3'h5;
	localparam logic [2:0] REG_TMRL = 3'h6;
	localparam logic [2:0] REG_TMRH = 3'h7;

	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] HI_RESET  = 8'hFF;
	localparam logic [7:0] LO_RESET  = 8'h00;

	localparam int CMD_EN  = 7;
	localparam int CMD_PD  = 6;
	localparam int CMD_TIM = 5;
	localparam int MUX_LO  = 2;
	localparam int WID_LO  = 0;
	localparam int CTL_FLG = 5;
	localparam int GAIN_LO = 2;
	localparam int PER_LO  = 0;
	localparam int ADR_SYNC = 7;
	localparam int ADR_CLR  = 6;

	typedef enum logic [1:0] {
		MUX_D1   = 2'h0,
		MUX_D2   = 2'h1,
		MUX_DIFF = 2'h2,
		MUX_NOP  = 2'h3
	} lsa_mux_t;

	typedef struct packed {
		logic       wrEn;
		logic [2:0] addr;
		logic [7:0] data;
		logic       syncCmd;
		logic       clearCmd;
	} lsa_hostwr_t;
endpackage

/* File: logic/lsa_sync2.sv */
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are levels from outside the clock domain
// Notes:   Only the second stage leaves this module
`timescale 1ns/1ps
module lsa_sync2 import lsa_pkg::*; #(
	parameter int W = 4
) (
	input  wire logic         clk,   // System clock
	input  wire logic         rst,   // Synchronous reset
	input  wire logic [W-1:0] din,   // Asynchronous levels
	input  wire logic [W-1:0] idle,  // Value held in reset
	output logic      [W-1:0] dout   // Synchronised levels
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= idle;
			dout   <= idle;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule

/* File: logic/lsa_twowire_slave.sv */
// Purpose: Two-wire serial slave giving access to eight registers
// Assumes: Line levels already synchronised; clock line far slower than clk
// Notes:   Pointer byte bits 7 and 6 are command strobes, bits 2:0 index
`timescale 1ns/1ps
module lsa_twowire_slave import lsa_pkg::*; (
	input  wire logic       clk,     // System clock
	input  wire logic       rst,     // Synchronous reset
	input  wire logic       scl,     // Synchronised clock line
	input  wire logic       sda,     // Synchronised data line
	output logic            sdaOe,   // High while pulling data low
	output lsa_hostwr_t     hostWr,  // Write and command pulses
	output logic [2:0]      rdAddr,  // Register being read
	input  wire logic [7:0] rdData   // Read value of rdAddr
);
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_ADDR  = 4'h1,
		ST_ACKA  = 4'h3,
		ST_PTR   = 4'h2,
		ST_ACKP  = 4'h6,
		ST_WDATA = 4'h7,
		ST_ACKW  = 4'h5,
		ST_RDATA = 4'h4,
		ST_RACK  = 4'hC
	} lsa_slv_t;

	lsa_slv_t   state_q;
	logic       sclD_q;
	logic       sdaD_q;
	logic [7:0] shift_q;
	logic [7:0] tx_q;
	logic [3:0] bitCnt_q;
	logic       rw_q;
	logic       nack_q;

	wire sclRise = scl & ~sclD_q;
	wire sclFall = ~scl & sclD_q;
	wire start   = scl & sclD_q & sdaD_q & ~sda;
	wire stop    = scl & sclD_q & ~sdaD_q & sda;

	always_ff @(posedge clk) begin
		if (rst) begin
			sclD_q <= 1'b1;
			sdaD_q <= 1'b1;
		end else begin
			sclD_q <= scl;
			sdaD_q <= sda;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q  <= ST_IDLE;
			sdaOe    <= 1'b0;
			hostWr   <= '0;
			rdAddr   <= 3'h0;
			shift_q  <= 8'h00;
			tx_q     <= 8'h00;
			bitCnt_q <= 4'h0;
			rw_q     <= 1'b0;
			nack_q   <= 1'b0;
		end else begin
			hostWr <= '0;
			if (start) begin
				state_q  <= ST_ADDR;
				bitCnt_q <= 4'h0;
				sdaOe    <= 1'b0;
			end else if (stop) begin
				state_q <= ST_IDLE;
				sdaOe   <= 1'b0;
			end else if (sclRise) begin
				if (state_q == ST_ADDR || state_q == ST_PTR || state_q == ST_WDATA) begin
					shift_q  <= {shift_q[6:0], sda};
					bitCnt_q <= bitCnt_q + 4'h1;
				end
				if (state_q == ST_RACK) begin
					nack_q <= sda;
					// Advance early so the next byte is ready by the falling edge
					if (!sda) begin
						rdAddr <= rdAddr + 3'h1;
					end
				end
			end else if (sclFall) begin
				unique case (state_q)
					ST_IDLE: begin
					end
					ST_ADDR: begin
						if (bitCnt_q == 4'h8) begin
							if (shift_q[7:1] == DEV_ADDR) begin
								rw_q    <= shift_q[0];
								sdaOe   <= 1'b1;
								state_q <= ST_ACKA;
							end else begin
								state_q <= ST_IDLE;
							end
						end
					end
					ST_ACKA: begin
						if (rw_q) begin
							tx_q     <= rdData;
							sdaOe    <= ~rdData[7];
							bitCnt_q <= 4'h1;
							state_q  <= ST_RDATA;
						end else begin
							sdaOe    <= 1'b0;
							bitCnt_q <= 4'h0;
							state_q  <= ST_PTR;
						end
					end
					ST_PTR: begin
						if (bitCnt_q == 4'h8) begin
							rdAddr          <= shift_q[2:0];
							hostWr.syncCmd  <= shift_q[ADR_SYNC];
							hostWr.clearCmd <= shift_q[ADR_CLR];
							sdaOe           <= 1'b1;
							state_q         <= ST_ACKP;
						end
					end
					ST_ACKP, ST_ACKW: begin
						if (state_q == ST_ACKW) begin
							rdAddr <= rdAddr + 3'h1;
						end
						sdaOe    <= 1'b0;
						bitCnt_q <= 4'h0;
						state_q  <= ST_WDATA;
					end
					ST_WDATA: begin
						if (bitCnt_q == 4'h8) begin
							hostWr.wrEn <= 1'b1;
							hostWr.addr <= rdAddr;
							hostWr.data <= shift_q;
							sdaOe       <= 1'b1;
							state_q     <= ST_ACKW;
						end
					end
					ST_RDATA: begin
						if (bitCnt_q == 4'h8) begin
							sdaOe   <= 1'b0;
							state_q <= ST_RACK;
						end else begin
							sdaOe    <= ~tx_q[3'(4'h7 - bitCnt_q)];
							bitCnt_q <= bitCnt_q + 4'h1;
						end
					end
					ST_RACK: begin
						if (nack_q) begin
							state_q <= ST_IDLE;
						end else begin
							tx_q     <= rdData;
							sdaOe    <= ~rdData[7];
							bitCnt_q <= 4'h1;
							state_q  <= ST_RDATA;
						end
					end
					default: begin
						state_q <= ST_IDLE;
						sdaOe   <= 1'b0;
					end
				endcase
			end
		end
	end

	chk_ack_addr: assert property (@(posedge clk) disable iff (rst)
		state_q == ST_ACKA |-> sdaOe) else $error("address not acknowledged");
endmodule

/* File: testbench/lsa_host_model.sv */
// Purpose: Two-wire bus master standing in for the host controller
// Assumes: Four clk per bus clock half period, 800 ns bus period
// Notes:   Data wire is open drain with a pull-up, released means high
`timescale 1ns/1ps
module lsa_host_model import lsa_pkg::*; (
	input  wire logic clk,   // System clock for bit timing
	input  wire logic devOe, // Device pulling data low
	output logic      scl,   // Serial clock pin
	output logic      sda    // Resolved data wire
);
	logic pullLow;

	assign sda = ~(pullLow | devOe);

	initial begin
		scl = 1'b1;
		pullLow = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Data moves only mid low phase, so no false start or stop appears
	task automatic bitOut(input logic b);
		scl <= 1'b0;
		tick(2);
		pullLow <= ~b;
		tick(2);
		scl <= 1'b1;
		tick(4);
	endtask

	// Start when first is 0, stop when first is 1
	task automatic cond(input logic first);
		scl <= 1'b0;
		tick(2);
		pullLow <= first;
		tick(2);
		scl <= 1'b1;
		tick(4);
		pullLow <= ~first;
		tick(4);
	endtask

	task automatic byteOut(input logic [7:0] v, output logic ack);
		for (int i = 7; i >= 0; i--) bitOut(v[i]);
		bitOut(1'b1);
		ack = ~sda;
	endtask

	// Pointer bits 7 and 6 carry the restart and clear strobes
	task automatic wr(input logic [7:0] ptr, input logic [7:0] dat, input bit withData,
		output logic ok);
		logic a1, a2, a3;
		cond(1'b0);
		byteOut({DEV_ADDR, 1'b0}, a1);
		byteOut(ptr, a2);
		a3 = 1'b1;
		if (withData) byteOut(dat, a3);
		cond(1'b1);
		ok = a1 & a2 & a3;
	endtask

	task automatic rd(input logic [7:0] ptr, output logic [7:0] v, output logic ok);
		logic a1, a2, a3;
		cond(1'b0);
		byteOut({DEV_ADDR, 1'b0}, a1);
		byteOut(ptr, a2);
		cond(1'b0);
		byteOut({DEV_ADDR, 1'b1}, a3);
		for (int i = 7; i >= 0; i--) begin
			bitOut(1'b1);
			v[i] = sda;
		end
		bitOut(1'b1);
		cond(1'b1);
		ok = a1 & a2 & a3;
	endtask
endmodule

/* File: testbench/lsa_light_sensor_bench.sv */
// Purpose: Self-checking bench of the light sensor control block
// Assumes: Width code 3 keeps integrations at 240 clk with gain 2 or 3
// Notes:   Diode streams give one edge every four clk while switched on
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
	$display("MISMATCH %s expected %0h seen %0h", nm, (exp), (got)); n_fail++; end end
module lsa_light_sensor_bench import lsa_pkg::*;;
	logic        clk, rst, sclIn, sdaIn, sdaOut, sdaOe, d1Pulse, d2Pulse;
	logic        intN, powerDown, d1On, d2On, ok;
	logic [1:0]  diodeSel, div;
	logic [16:0] fullScaleSpan;
	logic [7:0]  v;
	logic [15:0] r;
	int          n_fail, n_checks;

	lsa_light_sensor u_lsa_light_sensor (.clk(clk), .rst(rst), .sclIn(sclIn), .sdaIn(sdaIn),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .diode1Pulse(d1Pulse), .diode2Pulse(d2Pulse),
		.intN(intN), .powerDown(powerDown), .diodeSel(diodeSel), .fullScaleSpan(fullScaleSpan));
	lsa_host_model u_lsa_host_model (.clk(clk), .devOe(sdaOe), .scl(sclIn), .sda(sdaIn));

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		div = 2'h0;
		d1On = 1'b0;
		d2On = 1'b0;
		d1Pulse = 1'b0;
		d2Pulse = 1'b0;
		n_fail = 0;
		n_checks = 0;
	end
	always #50 clk = ~clk;
	always @(posedge clk) begin
		div <= div + 2'h1;
		d1Pulse <= d1On & div[1];
		d2Pulse <= d2On & div[1];
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wrReg(input logic [7:0] p, input logic [7:0] d);
		u_lsa_host_model.wr(p, d, 1'b1, ok);
		`CHK("write ack", 1'b1, ok)
	endtask
	task automatic strobe(input logic [7:0] p);
		u_lsa_host_model.wr(p, 8'h00, 1'b0, ok);
		`CHK("strobe ack", 1'b1, ok)
	endtask
	task automatic rdReg(input logic [7:0] p);
		u_lsa_host_model.rd(p, v, ok);
		`CHK("read ack", 1'b1, ok)
	endtask
	task automatic rd16(input logic [7:0] p);
		rdReg(p);
		r[7:0] = v;
		rdReg(p + 8'h01);
		r[15:8] = v;
	endtask

	task automatic t_reset;
		logic [7:0] exp [4] = '{8'h00, 8'h00, 8'hFF, 8'h00};
		`CHK("intN", 1'b1, intN)
		`CHK("powerDown", 1'b0, powerDown)
		`CHK("sdaOut", 1'b0, sdaOut)
		for (int i = 0; i < 4; i++) begin
			rdReg(8'(i));
			`CHK("reset value", exp[i], v)
		end
		d1On = 1'b1;
		wrReg(8'h04, 8'h55);
		tick(600);
		rd16(8'h04);
		`CHK("held core result", 16'h0000, r)
		$display("test reset done");
	endtask

	task automatic t_gain;
		logic [16:0] span [4] = '{17'd973, 17'd3892, 17'd15568, 17'd62272};
		for (int g = 0; g < 4; g++) begin
			wrReg(8'h01, 8'(g << 2));
			tick(2);
			`CHK("span", span[g], fullScaleSpan)
		end
		$display("test gain done");
	endtask

	task automatic t_modes;
		wrReg(8'h01, 8'h08);
		wrReg(8'h00, 8'h83);
		`CHK("diodeSel", 2'h0, diodeSel)
		tick(600);
		rd16(8'h04);
		`CHK("16 cycle result", 16'h000F, r)
		`CHK("in window intN", 1'b1, intN)
		wrReg(8'h00, 8'h82);
		tick(8000);
		rd16(8'h04);
		`CHK("256 cycle result", 16'h00FF, r)
		wrReg(8'h00, 8'h87);
		`CHK("diodeSel", 2'h1, diodeSel)
		tick(600);
		rd16(8'h04);
		`CHK("diode two result", 16'h0000, r)
		wrReg(8'h00, 8'h8F);
		d2On = 1'b1;
		tick(600);
		rd16(8'h04);
		`CHK("idle mode result", 16'h0000, r)
		d1On = 1'b0;
		wrReg(8'h00, 8'h8B);
		tick(1200);
		rd16(8'h04);
		`CHK("difference", 16'hFFF8, r)
		$display("test modes done");
	endtask

	task automatic t_external;
		d1On = 1'b1;
		d2On = 1'b0;
		wrReg(8'h00, 8'hA3);
		strobe(8'h80);
		tick(1500);
		strobe(8'h80);
		tick(50);
		rd16(8'h04);
		`CHK("unsaturated count", 1'b1, r > 16'h0010)
		rd16(8'h06);
		`CHK("timer span", 1'b1, r >= 16'd100 && r <= 16'd125)
		// Same strobe gap at the low range must give about half the ticks
		wrReg(8'h01, 8'h00);
		strobe(8'h80);
		tick(1500);
		strobe(8'h80);
		rd16(8'h06);
		`CHK("slow timer span", 1'b1, r >= 16'd50 && r <= 16'd62)
		wrReg(8'h01, 8'h08);
		$display("test external done");
	endtask

	task automatic t_interrupt;
		wrReg(8'h00, 8'h00);
		// The difference test leaves the flag set; start from a cleared pin
		strobe(8'h40);
		`CHK("start intN", 1'b1, intN)
		wrReg(8'h03, 8'h01);
		wrReg(8'h00, 8'h83);
		tick(400);
		`CHK("below low intN", 1'b0, intN)
		wrReg(8'h00, 8'h00);
		strobe(8'h40);
		wrReg(8'h03, 8'h00);
		wrReg(8'h02, 8'h00);
		wrReg(8'h01, 8'h09);
		wrReg(8'h00, 8'h83);
		tick(700);
		`CHK("persist early intN", 1'b1, intN)
		tick(600);
		`CHK("persist late intN", 1'b0, intN)
		rdReg(8'h01);
		`CHK("flag set", 8'h29, v)
		wrReg(8'h00, 8'h00);
		tick(300);
		`CHK("held intN", 1'b0, intN)
		strobe(8'h40);
		tick(5);
		`CHK("cleared intN", 1'b1, intN)
		rdReg(8'h01);
		`CHK("flag clear", 8'h09, v)
		$display("test interrupt done");
	endtask

	task automatic t_power;
		wrReg(8'h00, 8'h00);
		wrReg(8'h00, 8'h40);
		tick(2);
		`CHK("powerDown", 1'b1, powerDown)
		rdReg(8'h00);
		`CHK("cmd readback", 8'h40, v)
		wrReg(8'h00, 8'h00);
		tick(2);
		`CHK("powerDown", 1'b0, powerDown)
		$display("test power done");
	endtask

	task automatic close_out;
		$display("Checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Tests need about 32k clk; the limit leaves room for slow bus turns
	initial begin
		tick(70000);
		n_fail++;
		close_out();
	end

	initial begin
		tick(12);
		rst <= 1'b0;
		tick(5);
		t_reset();
		t_gain();
		t_modes();
		t_external();
		t_interrupt();
		t_power();
		close_out();
	end
endmodule
